/* File: reset_supervisor_watchdog_tb.sv */
// Purpose: self-checking bench for rsw_top
// Assumes: narrow counter keeps overflow short
// Notes: register writes come from rsw_core_model
`timescale 1ns/1ps
module reset_supervisor_watchdog_tb;
  localparam W = 12;
  logic sys_clk = 0, sys_rst = 1, ext_reset_n = 1, low_supply_detect = 0;
  logic debug_reset_req = 0, core_idle = 0, core_power_down = 0;
  logic mem_xfer = 0, prefetch_stall = 0, cold_flag_clr = 0;
  logic [3:0] bus_cycle_clks = 4'h4;
  logic [7:0] r;
  logic [W-1:0] d;
  wire key_wr, reload_wr, cold_start_q, core_reset_q, logic_reset_n_q;
  wire watchdog_enabled;
  wire [7:0] wr_data;
  wire [15:0] reset_vector;
  wire [W-1:0] watchdog_count;
  int bad_count = 0, checked = 0, seed = 32'h4052, b, i, s;
  rsw_top #(.WD_W(W)) dut (.sys_clk, .sys_rst, .ext_reset_n,
    .low_supply_detect, .debug_reset_req, .core_idle, .core_power_down,
    .mem_xfer, .bus_cycle_clks, .prefetch_stall, .key_wr, .reload_wr,
    .wr_data, .cold_flag_clr, .cold_start_q, .core_reset_q,
    .logic_reset_n_q, .reset_vector, .watchdog_enabled, .watchdog_count);
  rsw_core_model u_core (.sys_clk, .core_reset_q, .key_wr, .reload_wr,
    .wr_data);
  initial forever #50 sys_clk = ~sys_clk;
  task cyc(input int n); repeat (n) @(posedge sys_clk); endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Counts expected in 40 clocks: mode 3 uses the bus length b
  function int span(input int k);
    if (k < 3 || k == 5) return 0;
    return 40 / (k == 3 ? b : 4);
  endfunction
  initial begin #1000000; bad_count++; end_of_test; end
  initial begin
    cyc(4);
    sys_rst <= 0;
    cyc(20);
    @(negedge sys_clk);
    chk({core_reset_q, cold_start_q, watchdog_enabled}, 3'b010);
    chk(reset_vector, 16'h0000);
    for (i = 0; i < 6; i++) begin
      cyc(1);
      b = 4 + ($random(seed) & 7);
      r = $random(seed) & 8'h7F;
      bus_cycle_clks <= b[3:0];
      {core_idle, core_power_down, prefetch_stall, mem_xfer} <=
        (i < 4) ? 4'h8 >> i : 4'h0;
      u_core.wr(0, (i == 5) ? 8'h55 : 8'h55 ^ (8'h01 << (b - 4)));
      u_core.wr(1, r);
      @(negedge sys_clk);
      chk(watchdog_count, {r, 4'h0});
      cyc(40);
      @(negedge sys_clk);
      d = watchdog_count - {r, 4'h0};
      s = span(i);
      chk(d >= s - (s > 0) && d <= s + (s > 0), 1);
    end
    {core_idle, core_power_down, prefetch_stall, mem_xfer} <= 4'h0;
    u_core.wr(0, 8'hA5);
    repeat (3) begin u_core.wr(1, 8'hFF); cyc(40); end
    chk(core_reset_q, 0);
    // Overflow reset stands only one cycle: look at each negedge
    for (i = 0; i < 200 && !core_reset_q; i++) @(negedge sys_clk);
    chk({core_reset_q, logic_reset_n_q}, 2'b10);
    cyc(10);
    @(negedge sys_clk);
    chk({core_reset_q, watchdog_enabled, watchdog_count}, 0);
    cyc(1);
    ext_reset_n <= 0;
    cold_flag_clr <= 1;
    cyc(2);
    ext_reset_n <= 1;
    cold_flag_clr <= 0;
    cyc(8);
    @(negedge sys_clk);
    chk({core_reset_q, cold_start_q}, 0);
    for (i = 0; i < 3; i++) begin
      u_core.wr(0, 8'hAA);
      core_power_down <= 1;
      {ext_reset_n, debug_reset_req, low_supply_detect} <=
        (i == 0) ? 3'b000 : (i == 1) ? 3'b110 : 3'b101;
      cyc(12);
      @(negedge sys_clk);
      chk({core_reset_q, logic_reset_n_q, watchdog_enabled, cold_start_q},
        {3'b100, i == 2});
      cyc(1);
      {ext_reset_n, debug_reset_req, low_supply_detect} <= 3'b100;
      cyc(8);
      @(negedge sys_clk);
      chk(core_reset_q, i == 2);
      cyc(10);
      @(negedge sys_clk);
      chk(core_reset_q, 0);
      core_power_down <= 0;
    end
    end_of_test;
  end
endmodule // reset_supervisor_watchdog_tb

/* File: rsw_core_model.sv */
// Purpose: core side writing key and reload registers
// Assumes: writes are held off until core reset goes low
// Notes: data line shows the inverse once released
`timescale 1ns/1ps
module rsw_core_model (
  // Clock and status
  input wire sys_clk,
  input wire core_reset_q,
  // Write strobes
  output logic key_wr,
  output logic reload_wr,
  output logic [7:0] wr_data
);
  initial {key_wr, reload_wr, wr_data} = 10'h000;
  // Refresh cadence is left to the caller
  task wr(input logic sel, input logic [7:0] d);
    @(posedge sys_clk);
    while (core_reset_q) @(posedge sys_clk);
    key_wr <= !sel;
    reload_wr <= sel;
    wr_data <= d;
    @(posedge sys_clk);
    {key_wr, reload_wr} <= 2'b00;
    wr_data <= ~d;
  endtask
endmodule // rsw_core_model

/* File: rsw_defs.vh */
// Purpose: constants for the reset supervisor and watchdog
// Assumes: core clock sys_clk at 10 MHz
// Notes: times in ns, counts derived from the clock period
`ifndef RSW_DEFS_VH
`define RSW_DEFS_VH
`define RSW_CLK_PERIOD_NS 100
`define RSW_KEY_OFF_VAL 8'h55
`define RSW_WD_WIDTH 24
`define RSW_WD_CLEAR 24'h000000
`define RSW_WD_LOW_CLEAR 16'h0000
`define RSW_MC_BASE 4'h4
`define RSW_RESET_VECTOR 16'h0000
`define RSW_HOLD_TIME_NS 1000
`define RSW_FILTER_TIME_NS 300
`define RSW_CNT_W 16
`endif

/* File: rsw_pin_filter.v */
// Purpose: synchronise and deglitch an asynchronous active-low pin
// Assumes: pin is from outside the sys_clk domain
// Notes: output changes only after FILT_CYC equal samples
`timescale 1ns/1ps
module rsw_pin_filter #(
  parameter FILT_CYC = 3,
  parameter RST_VAL = 1'b1
) (
  // Clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // Pin side
  input wire pin_in,
  // Filtered level
  output reg level_q
);
  reg sync1_q;
  reg sync2_q;
  reg [7:0] cnt_q;
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      sync1_q <= RST_VAL;
      sync2_q <= RST_VAL;
      cnt_q <= 8'h00;
      level_q <= RST_VAL;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      // Spikes shorter than the filter never reach the output
      if (sync2_q == level_q) begin
        cnt_q <= 8'h00;
      end else if (cnt_q >= FILT_CYC[7:0] - 8'h01) begin
        cnt_q <= 8'h00;
        level_q <= sync2_q;
      end else begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end
endmodule // rsw_pin_filter

/* File: rsw_top.v */
// Purpose: reset supervisor merging four sources, with watchdog timer
// Assumes: core accesses key and reload registers by write strobes
// Notes: machine cycle length follows bus wait and stall inputs
// Functional notes
// - Any of four sources drives core reset
// - Core held in reset, restarts at zero
// - Active-low reset also driven to logic
// - Pin reset lasts only while pin active
// - Short pin glitches ignored; host holds long
// - Supply recovery holds reset a fixed time
// - Supply reset path always enabled, any mode
// - Cold-start flag set, cleared by software only
// - Debug reset works in idle and power-down
// - Enabled watchdog overflow causes core reset
// - Watchdog stops in idle and power-down
// - Key 55h disables; every reset reloads 55h
// - 24-bit up-counter cleared by every reset
// - Overflow resets and restores key to 55h
// - Reload write sets high byte, clears low
// - Machine cycle four clocks, longer bus waits
// - Stalls stretch machine cycle, slowing count
`timescale 1ns/1ps
`include "rsw_defs.vh"
module rsw_top #(
  parameter WD_W = `RSW_WD_WIDTH,
  parameter HOLD_CYC = (`RSW_HOLD_TIME_NS + `RSW_CLK_PERIOD_NS - 1) /
    `RSW_CLK_PERIOD_NS,
  parameter FILT_CYC = (`RSW_FILTER_TIME_NS + `RSW_CLK_PERIOD_NS - 1) /
    `RSW_CLK_PERIOD_NS
) (
  // Clock and power-on reset
  input wire sys_clk,
  input wire sys_rst,
  // Reset sources
  input wire ext_reset_n,
  input wire low_supply_detect,
  input wire debug_reset_req,
  // Core power state
  input wire core_idle,
  input wire core_power_down,
  // Machine cycle shaping
  input wire mem_xfer,
  input wire [3:0] bus_cycle_clks,
  input wire prefetch_stall,
  // Register writes from the core
  input wire key_wr,
  input wire reload_wr,
  input wire [7:0] wr_data,
  // Cold-start flag
  input wire cold_flag_clr,
  output reg cold_start_q,
  // Reset outputs
  output reg core_reset_q,
  output reg logic_reset_n_q,
  output wire [15:0] reset_vector,
  // Watchdog state
  output wire watchdog_enabled,
  output wire [WD_W-1:0] watchdog_count
);

  // Hold sequencer states
  localparam [1:0] HS_RUN = 2'b00;
  localparam [1:0] HS_LOW = 2'b01;
  localparam [1:0] HS_HOLD = 2'b10;

  // Synchroniser reset values: supply low, no debug request
  localparam [1:0] SYNC_RST = 2'b01;

  // Hold counter constants
  localparam [`RSW_CNT_W-1:0] HOLD_CNT = HOLD_CYC[`RSW_CNT_W-1:0];
  localparam [`RSW_CNT_W-1:0] CNT_ZERO = {`RSW_CNT_W{1'b0}};
  localparam [`RSW_CNT_W-1:0] CNT_ONE = {{(`RSW_CNT_W-1){1'b0}}, 1'b1};

  // Watchdog constants, sized to the counter width
  localparam [WD_W-1:0] WD_ZERO = {WD_W{1'b0}};
  localparam [WD_W-1:0] WD_ONE = {{(WD_W-1){1'b0}}, 1'b1};
  // Reload byte fills the top; everything below it is cleared
  localparam [WD_W-9:0] WD_LOW_ZERO = {(WD_W-8){1'b0}};

  // Machine cycle counter constants
  localparam [3:0] MC_ZERO = 4'h0;
  localparam [3:0] MC_ONE = 4'h1;

  // Synchronised and filtered sources
  wire pin_level;
  wire [1:0] async_in;
  wire lsd_sync;
  wire dbg_sync;
  wire hold_active;

  // Watchdog control
  wire wd_run;
  wire mc_done;
  wire [3:0] mc_len;

  // Registers and their next values
  reg [1:0] hold_state_q;
  reg [1:0] hold_state_d;
  reg [`RSW_CNT_W-1:0] hold_cnt_q;
  reg [`RSW_CNT_W-1:0] hold_cnt_d;
  reg core_reset_d;
  reg cold_start_d;
  reg [3:0] mc_cnt_q;
  reg [3:0] mc_cnt_d;
  reg [7:0] key_q;
  reg [7:0] key_d;
  reg [WD_W-1:0] wd_cnt_q;
  reg [WD_W-1:0] wd_cnt_d;
  reg wd_ovf_q;
  reg wd_ovf_d;
  genvar g;

  // Key decode shared by the run gate and the status output
  function key_enables;
    input [7:0] key;
    begin
      key_enables = (key != `RSW_KEY_OFF_VAL);
    end
  endfunction

  // Filtered external pin, level high when released
  rsw_pin_filter #(
    .FILT_CYC(FILT_CYC),
    .RST_VAL(1'b1)
  ) u_pin (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .pin_in(ext_reset_n),
    .level_q(pin_level)
  );

  // Two-stage sync of the other asynchronous sources
  assign async_in = {debug_reset_req, low_supply_detect};
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_sync
      reg s1_q;
      reg s2_q;
      always @(posedge sys_clk) begin
        if (sys_rst) begin
          s1_q <= SYNC_RST[g];
          s2_q <= SYNC_RST[g];
        end else begin
          s1_q <= async_in[g];
          s2_q <= s1_q;
        end
      end
    end
  endgenerate
  assign lsd_sync = g_sync[0].s2_q;
  assign dbg_sync = g_sync[1].s2_q;

  // Hold sequencer: supply low, then a fixed hold after recovery.
  // No power mode or register reaches it, so it cannot be disabled.
  always @* begin
    hold_state_d = hold_state_q;
    hold_cnt_d = hold_cnt_q;
    if (lsd_sync) begin
      hold_state_d = HS_LOW;
      hold_cnt_d = HOLD_CNT;
    end else begin
      case (hold_state_q)
        HS_LOW, HS_HOLD: begin
          if (hold_cnt_q != CNT_ZERO) begin
            hold_state_d = HS_HOLD;
            hold_cnt_d = hold_cnt_q - CNT_ONE;
          end else begin
            hold_state_d = HS_RUN;
          end
        end
        HS_RUN: begin
          hold_state_d = HS_RUN;
        end
        default: begin
          hold_state_d = HS_RUN;
          hold_cnt_d = CNT_ZERO;
        end
      endcase
    end
  end

  // Power-on starts as if the supply had just been low
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      hold_state_q <= HS_LOW;
      hold_cnt_q <= HOLD_CNT;
    end else begin
      hold_state_q <= hold_state_d;
      hold_cnt_q <= hold_cnt_d;
    end
  end
  assign hold_active = (hold_state_q != HS_RUN);

  // Pin term is not stretched; debug term ignores power state
  always @* begin
    core_reset_d = !pin_level || lsd_sync || hold_active ||
      dbg_sync || wd_ovf_q;
  end

  // Both reset outputs come from one decision, so they never skew
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      core_reset_q <= 1'b1;
      logic_reset_n_q <= 1'b0;
    end else begin
      core_reset_q <= core_reset_d;
      logic_reset_n_q <= !core_reset_d;
    end
  end

  // Core fetches from this vector after release
  assign reset_vector = `RSW_RESET_VECTOR;

  // Cold-start flag: a supply event beats a clear in the same cycle
  always @* begin
    cold_start_d = cold_start_q;
    if (lsd_sync) begin
      cold_start_d = 1'b1;
    end else if (cold_flag_clr && !core_reset_q) begin
      cold_start_d = 1'b0;
    end
  end
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      cold_start_q <= 1'b0;
    end else begin
      cold_start_q <= cold_start_d;
    end
  end

  // Machine cycle length: base four, longer bus cycles stretch it
  assign mc_len = (mem_xfer && bus_cycle_clks > `RSW_MC_BASE) ?
    bus_cycle_clks : `RSW_MC_BASE;
  // A stall parks the counter on the last clock of the cycle
  assign mc_done = !prefetch_stall &&
    (mc_cnt_q >= mc_len - MC_ONE);
  always @* begin
    mc_cnt_d = mc_cnt_q;
    if (core_reset_q || mc_done) begin
      mc_cnt_d = MC_ZERO;
    end else if (!prefetch_stall || mc_cnt_q < mc_len - MC_ONE) begin
      mc_cnt_d = mc_cnt_q + MC_ONE;
    end
  end
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      mc_cnt_q <= MC_ZERO;
    end else begin
      mc_cnt_q <= mc_cnt_d;
    end
  end

  // Counting stops in idle, power-down and while the core is held
  assign wd_run = key_enables(key_q) && !core_idle &&
    !core_power_down && !core_reset_q;

  // Key register; every reset and every overflow restore the off value
  always @* begin
    key_d = key_q;
    if (core_reset_q || wd_ovf_q) begin
      key_d = `RSW_KEY_OFF_VAL;
    end else if (key_wr) begin
      key_d = wr_data;
    end
  end
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      key_q <= `RSW_KEY_OFF_VAL;
    end else begin
      key_q <= key_d;
    end
  end

  // Counter; reload write wins over a count in the same cycle
  always @* begin
    wd_cnt_d = wd_cnt_q;
    wd_ovf_d = 1'b0;
    if (core_reset_q) begin
      wd_cnt_d = WD_ZERO;
    end else if (reload_wr) begin
      wd_cnt_d = {wr_data, WD_LOW_ZERO};
    end else if (wd_run && mc_done) begin
      wd_cnt_d = wd_cnt_q + WD_ONE;
      wd_ovf_d = &wd_cnt_q;
    end
  end
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      wd_cnt_q <= WD_ZERO;
      wd_ovf_q <= 1'b0;
    end else begin
      wd_cnt_q <= wd_cnt_d;
      wd_ovf_q <= wd_ovf_d;
    end
  end

  // Status outputs
  assign watchdog_enabled = key_enables(key_q);
  assign watchdog_count = wd_cnt_q;
endmodule // rsw_top

/* File: rsw_top_assertions.sv */
// Purpose: port checks for the reset supervisor
// Assumes: one clock, synchronous reset
// Notes: latencies follow the hand-over figures
`timescale 1ns/1ps
module rsw_top_chk #(parameter WD_W = 24) (
  // Clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // Inputs
  input wire ext_reset_n,
  input wire low_supply_detect,
  input wire core_idle,
  input wire core_power_down,
  input wire reload_wr,
  input wire [7:0] wr_data,
  // Outputs
  input wire cold_start_q,
  input wire core_reset_q,
  input wire logic_reset_n_q,
  input wire [15:0] reset_vector,
  input wire watchdog_enabled,
  input wire [WD_W-1:0] watchdog_count
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence wrap_s;
    !$past(reload_wr) && $past(&watchdog_count) && watchdog_count == 0;
  endsequence
  sequence ovf_tail_s;
    ##1 core_reset_q ##1 (!watchdog_enabled && watchdog_count == 0);
  endsequence
  out_inverse_a: assert property (logic_reset_n_q == !core_reset_q)
    else $error("logic reset not inverse of core reset");
  vector_zero_a: assert property (reset_vector == 16'h0000)
    else $error("reset vector not zero");
  reset_defaults_a: assert property ($fell(sys_rst) |->
    core_reset_q && !watchdog_enabled && watchdog_count == 0)
    else $error("bad state after reset");
  reload_load_a: assert property (reload_wr && !core_reset_q |=>
    watchdog_count == {$past(wr_data), {(WD_W-8){1'b0}}})
    else $error("reload did not load count");
  count_hold_a: assert property ((core_idle || core_power_down ||
    !watchdog_enabled) && !reload_wr && !core_reset_q |=>
    core_reset_q || $stable(watchdog_count)) else $error("count moved");
  overflow_reset_a: assert property (wrap_s |-> ovf_tail_s)
    else $error("overflow did not reset and disable");
  supply_hold_a: assert property (low_supply_detect[*4]
    ##1 !low_supply_detect |-> core_reset_q[*8] ##[1:8] !core_reset_q)
    else $error("supply hold wrong");
  pin_assert_a: assert property (!ext_reset_n[*8] |-> core_reset_q)
    else $error("pin low without core reset");
  pin_release_a: assert property ($rose(ext_reset_n)
    |-> ##[1:8] !core_reset_q) else $error("pin reset stretched");
  cold_set_a: assert property (low_supply_detect[*4] |-> cold_start_q)
    else $error("cold flag not set");
endmodule // rsw_top_chk
bind rsw_top rsw_top_chk #(.WD_W(WD_W)) u_chk (.sys_clk, .sys_rst,
  .ext_reset_n, .low_supply_detect, .core_idle, .core_power_down,
  .reload_wr, .wr_data, .cold_start_q, .core_reset_q, .logic_reset_n_q,
  .reset_vector, .watchdog_enabled, .watchdog_count);
